// file: rtl/reset_bus_pkg.sv
package reset_bus_pkg;

	localparam int ADDR_W = 16;
	localparam int UPPER_W = 3;

	// bus cycle kinds requested by the core
	typedef enum logic [2:0] {
		CYC_IDLE = 3'b000,
		CYC_READ = 3'b001,
		CYC_WRITE = 3'b010,
		CYC_HALT = 3'b011,
		CYC_OTHER = 3'b100
	} cycle_kind_type;

	// bus states of the pin sequencer
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_IDLE = 3'b001,
		ST_T1 = 3'b010,
		ST_T2 = 3'b011,
		ST_HALT_T1 = 3'b100,
		ST_HALT_T2 = 3'b101,
		ST_LOWPWR = 3'b110
	} bus_state_type;

	// bus control outputs, active high inside, inactive = 0
	typedef struct packed {
		logic ale;
		logic rd;
		logic wr;
		logic den;
		logic lock;
	} bus_ctrl_type;

	// cycle request from the core
	typedef struct packed {
		logic valid;
		cycle_kind_type kind;
		logic [ADDR_W-1:0] addr;
		logic [UPPER_W:0] upper;
		logic [ADDR_W-1:0] wdata;
		logic lock;
	} cycle_req_type;

	localparam bus_ctrl_type CTRL_INACTIVE = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
	localparam logic [UPPER_W:0] UPPER_ZERO = 4'h0;
	localparam logic [UPPER_W:0] UPPER_ONES = 4'hf;
	localparam int TOP_BIT = UPPER_W;

endpackage

// file: rtl/sync_2ff.sv
module sync_2ff #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage_q;
	logic [WIDTH-1:0] out_q;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stage_q <= RESET_VAL;
			out_q <= RESET_VAL;
		end else begin
			stage_q <= async_i;
			out_q <= stage_q;
		end
	end

	assign sync_o = out_q;
endmodule

// file: rtl/reset_entry_bus_state_control.sv
// Summary of operation
// - reset input synchronised on internal clock first
// - reset aborts bus cycle, defined state
// - controls driven inactive, then floated
// - lock and upper address become pulled-up inputs
// - only top address low; means test isolation
// - halt after read: data lines float first state
// - halt after non-read: lines driven, junk data
// - halt: invalid address, controls inactive
// - powerdown: address lines drive zero; idle: muxed lines float, upper address stays driven
module reset_entry_bus_state_control (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic reset_request_n_i,
	input wire reset_bus_pkg::cycle_req_type req_i,
	input wire logic low_power_i,
	input wire logic top_address_strap_pin_i,
	output logic core_reset_o,
	output logic test_isolation_strap_o,
	output reset_bus_pkg::bus_ctrl_type ctrl_o,
	output logic ctrl_oe_o,
	output logic [reset_bus_pkg::ADDR_W-1:0] muxed_addr_data_lines_o,
	output logic muxed_addr_data_lines_oe_o,
	output logic [reset_bus_pkg::UPPER_W:0] upper_address_pins_o,
	output logic upper_address_pins_oe_o,
	output logic pullup_en_o,
	output logic cycle_done_o
);
	logic req_sync_n;
	logic strap_sync;

	// reset request passes two flops first
	sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.async_i(reset_request_n_i),
		.sync_o(req_sync_n)
	);

	sync_2ff #(.WIDTH(1), .RESET_VAL(1'b1)) u_strap_sync (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.async_i(top_address_strap_pin_i),
		.sync_o(strap_sync)
	);

	reset_bus_pkg::bus_state_type state_q, state_d;
	logic float_pend_q, float_pend_d;
	logic last_read_q, last_read_d;
	logic in_reset_q, in_reset_d;
	logic strap_q, strap_d;
	logic done_q, done_d;
	reset_bus_pkg::bus_ctrl_type ctrl_q, ctrl_d;
	logic ctrl_oe_q, ctrl_oe_d;
	logic [reset_bus_pkg::ADDR_W-1:0] ad_q, ad_d;
	logic ad_oe_q, ad_oe_d;
	logic [reset_bus_pkg::UPPER_W:0] up_q, up_d;
	logic up_oe_q, up_oe_d;
	logic pull_q, pull_d;
	reset_bus_pkg::cycle_req_type cur_q, cur_d;

	always_comb begin
		state_d = state_q;
		float_pend_d = 1'b0;
		last_read_d = last_read_q;
		in_reset_d = !req_sync_n;
		strap_d = strap_q;
		done_d = 1'b0;
		ctrl_d = reset_bus_pkg::CTRL_INACTIVE;
		ctrl_oe_d = ctrl_oe_q;
		ad_d = ad_q;
		ad_oe_d = ad_oe_q;
		up_d = up_q;
		up_oe_d = up_oe_q;
		pull_d = 1'b0;
		cur_d = cur_q;
		if (!req_sync_n) begin
			// abort at once; controls inactive this cycle, float the next
			state_d = reset_bus_pkg::ST_RESET;
			ctrl_d = reset_bus_pkg::CTRL_INACTIVE;
			ctrl_oe_d = in_reset_q ? 1'b0 : 1'b1;
			float_pend_d = !in_reset_q;
			ad_oe_d = 1'b0;
			up_oe_d = 1'b0;
			pull_d = 1'b1;
			last_read_d = 1'b0;
			cur_d = '0;
		end else if (in_reset_q) begin
			// latch strap on the release edge
			strap_d = !strap_sync;
			state_d = reset_bus_pkg::ST_IDLE;
			ctrl_oe_d = 1'b1;
			up_oe_d = 1'b1;
			up_d = reset_bus_pkg::UPPER_ZERO;
		end else begin
			case (state_q)
			reset_bus_pkg::ST_IDLE,
			reset_bus_pkg::ST_RESET: begin
				ad_oe_d = 1'b0;
				if (low_power_i) begin
					state_d = reset_bus_pkg::ST_LOWPWR;
				end else if (req_i.valid) begin
					cur_d = req_i;
					if (req_i.kind == reset_bus_pkg::CYC_HALT) begin
						state_d = reset_bus_pkg::ST_HALT_T1;
						ad_oe_d = !last_read_q;
						ad_d = ~ad_q;
						up_d = reset_bus_pkg::UPPER_ONES;
						ctrl_d = reset_bus_pkg::CTRL_INACTIVE;
					end else begin
						state_d = reset_bus_pkg::ST_T1;
						ad_oe_d = 1'b1;
						ad_d = req_i.addr;
						up_d = req_i.upper;
						ctrl_d.ale = 1'b1;
						ctrl_d.lock = req_i.lock;
					end
				end
			end
			reset_bus_pkg::ST_T1: begin
				state_d = reset_bus_pkg::ST_T2;
				ctrl_d.lock = cur_q.lock;
				ctrl_d.den = 1'b1;
				if (cur_q.kind == reset_bus_pkg::CYC_READ) begin
					ctrl_d.rd = 1'b1;
					ad_oe_d = 1'b0;
				end else begin
					ctrl_d.wr = 1'b1;
					ad_d = cur_q.wdata;
				end
			end
			reset_bus_pkg::ST_T2: begin
				state_d = reset_bus_pkg::ST_IDLE;
				done_d = 1'b1;
				last_read_d = cur_q.kind == reset_bus_pkg::CYC_READ;
				ad_oe_d = 1'b0;
			end
			reset_bus_pkg::ST_HALT_T1: begin
				state_d = reset_bus_pkg::ST_HALT_T2;
				ad_oe_d = 1'b0;
			end
			reset_bus_pkg::ST_HALT_T2: begin
				done_d = 1'b1;
				last_read_d = 1'b0;
				state_d = low_power_i ? reset_bus_pkg::ST_LOWPWR
					: reset_bus_pkg::ST_IDLE;
			end
			reset_bus_pkg::ST_LOWPWR: begin
				ad_oe_d = 1'b1;
				ad_d = reset_bus_pkg::ADDR_ZERO;
				up_d = reset_bus_pkg::UPPER_ZERO;
				if (!low_power_i) begin
					state_d = reset_bus_pkg::ST_IDLE;
					ad_oe_d = 1'b0;
				end
			end
			default: state_d = reset_bus_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= reset_bus_pkg::ST_RESET;
			float_pend_q <= 1'b0;
			last_read_q <= 1'b0;
			in_reset_q <= 1'b1;
			strap_q <= 1'b0;
			done_q <= 1'b0;
			ctrl_q <= reset_bus_pkg::CTRL_INACTIVE;
			ctrl_oe_q <= 1'b0;
			ad_q <= reset_bus_pkg::ADDR_ZERO;
			ad_oe_q <= 1'b0;
			up_q <= reset_bus_pkg::UPPER_ZERO;
			up_oe_q <= 1'b0;
			pull_q <= 1'b1;
			cur_q <= '0;
		end else begin
			state_q <= state_d;
			float_pend_q <= float_pend_d;
			last_read_q <= last_read_d;
			in_reset_q <= in_reset_d;
			strap_q <= strap_d;
			done_q <= done_d;
			ctrl_q <= ctrl_d;
			ctrl_oe_q <= ctrl_oe_d;
			ad_q <= ad_d;
			ad_oe_q <= ad_oe_d;
			up_q <= up_d;
			up_oe_q <= up_oe_d;
			pull_q <= pull_d;
			cur_q <= cur_d;
		end
	end

	assign core_reset_o = in_reset_q;
	assign test_isolation_strap_o = strap_q;
	assign ctrl_o = ctrl_q;
	assign ctrl_oe_o = ctrl_oe_q;
	assign muxed_addr_data_lines_o = ad_q;
	assign muxed_addr_data_lines_oe_o = ad_oe_q;
	assign upper_address_pins_o = up_q;
	assign upper_address_pins_oe_o = up_oe_q;
	assign pullup_en_o = pull_q;
	assign cycle_done_o = done_q;

	sequence s_pin_held_low;
		!reset_request_n_i [*3];
	endsequence
	property p_reset_takes_hold;
		@(posedge clock_i) disable iff (!resetn_i)
		s_pin_held_low |=> in_reset_q;
	endproperty
	a_reset_takes_hold: assert property (p_reset_takes_hold)
		else $error("reset request not taken after sync");

	property p_reset_aborts;
		@(posedge clock_i) disable iff (!resetn_i)
		(!req_sync_n) |=> (ctrl_q == reset_bus_pkg::CTRL_INACTIVE)
			&& !ad_oe_q;
	endproperty
	a_reset_aborts: assert property (p_reset_aborts)
		else $error("bus still active in reset");

	sequence s_enter_reset;
		$rose(in_reset_q) && ctrl_oe_q;
	endsequence
	property p_float_after_drive;
		@(posedge clock_i) disable iff (!resetn_i)
		s_enter_reset |=> !ctrl_oe_q && ctrl_q == reset_bus_pkg::CTRL_INACTIVE;
	endproperty
	a_float_after_drive: assert property (p_float_after_drive)
		else $error("controls not floated after inactive drive");

	property p_pins_inputs;
		@(posedge clock_i) disable iff (!resetn_i)
		in_reset_q |-> !up_oe_q && pullup_en_o;
	endproperty
	a_pins_inputs: assert property (p_pins_inputs)
		else $error("upper pins driven in reset");

	property p_strap_latch;
		@(posedge clock_i) disable iff (!resetn_i)
		(in_reset_q && req_sync_n) |=> strap_q == !$past(strap_sync);
	endproperty
	a_strap_latch: assert property (p_strap_latch)
		else $error("strap not latched at release");

	property p_strap_hold;
		@(posedge clock_i) disable iff (!resetn_i)
		(!in_reset_q && req_sync_n) |=> $stable(strap_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("strap changed outside reset");

	property p_halt_after_read;
		@(posedge clock_i) disable iff (!resetn_i)
		state_q == reset_bus_pkg::ST_HALT_T1 && $past(last_read_q)
			&& !in_reset_q |-> !ad_oe_q;
	endproperty
	a_halt_after_read: assert property (p_halt_after_read)
		else $error("data lines driven in halt after read");

	property p_halt_drive;
		@(posedge clock_i) disable iff (!resetn_i)
		state_q == reset_bus_pkg::ST_HALT_T1 && !$past(last_read_q)
			&& !in_reset_q |-> ad_oe_q;
	endproperty
	a_halt_drive: assert property (p_halt_drive)
		else $error("data lines float in halt after non-read");

	property p_halt_ctrl;
		@(posedge clock_i) disable iff (!resetn_i)
		state_q == reset_bus_pkg::ST_HALT_T1
			|-> ctrl_q == reset_bus_pkg::CTRL_INACTIVE ##1
			ctrl_q == reset_bus_pkg::CTRL_INACTIVE;
	endproperty
	a_halt_ctrl: assert property (p_halt_ctrl)
		else $error("control active in halt");

	property p_lowpwr_zero;
		@(posedge clock_i) disable iff (!resetn_i)
		state_q == reset_bus_pkg::ST_LOWPWR && low_power_i && req_sync_n
			|=> ad_q == reset_bus_pkg::ADDR_ZERO && ad_oe_q
			&& up_q == reset_bus_pkg::UPPER_ZERO;
	endproperty
	a_lowpwr_zero: assert property (p_lowpwr_zero)
		else $error("address not zero in low power");
endmodule

// file: sim/reset_supervisor_model.sv
module reset_supervisor_model #(
	parameter int STABLE_CYCLES = 4
) (
	input wire logic clock_i,
	input wire logic hold_reset_i,
	input wire logic strap_low_i,
	input wire logic pin_oe_i,
	input wire logic pin_drive_i,
	input wire logic pullup_en_i,
	output logic reset_request_n_o,
	output logic top_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int stable_q = 0;
	logic last_q = 1'b1;
	initial reset_request_n_o = 1'b0;
	// release only after clock has run a while
	always @(negedge clock_i) begin
		if (hold_reset_i) begin
			stable_q <= 0;
			reset_request_n_o <= 1'b0;
		end else if (stable_q < STABLE_CYCLES) begin
			stable_q <= stable_q + 1;
		end else begin
			reset_request_n_o <= 1'b1;
		end
	end
	// only the top pin is pulled low, lock and others never
	always @* begin
		if (pin_oe_i) top_pin_o = pin_drive_i;
		else if (strap_low_i) top_pin_o = 1'b0;
		else if (pullup_en_i) top_pin_o = 1'b1;
		else top_pin_o = ~last_q;
	end
	always @(posedge clock_i) last_q <= top_pin_o;
endmodule

// file: sim/reset_entry_bus_state_control_bench.sv
module reset_entry_bus_state_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] kind;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [4:0] ctrl1;
		logic oe1;
		logic [4:0] ctrl2;
		logic oe2;
		logic chk;
	} row_type;
	row_type rows [7] = '{
		'{3'h1, 16'h1234, 16'h0000, 5'h10, 1'b1, 5'h0a, 1'b0, 1'b1},
		'{3'h3, 16'h0000, 16'h0000, 5'h00, 1'b0, 5'h00, 1'b0, 1'b1},
		'{3'h2, 16'habcd, 16'h5a5a, 5'h10, 1'b1, 5'h06, 1'b1, 1'b1},
		'{3'h3, 16'h0000, 16'h0000, 5'h00, 1'b1, 5'h00, 1'b0, 1'b1},
		'{3'h4, 16'h0001, 16'h0000, 5'h00, 1'b0, 5'h00, 1'b0, 1'b0},
		'{3'h3, 16'h0000, 16'h0000, 5'h00, 1'b1, 5'h00, 1'b0, 1'b1},
		'{3'h1, 16'hffff, 16'h0000, 5'h10, 1'b1, 5'h0a, 1'b0, 1'b1}
	};
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic low_power_i = 1'b0;
	logic hold_reset = 1'b0;
	logic strap_low = 1'b0;
	logic rq_n, top_pin, core_reset_o, test_isolation_strap_o;
	logic ctrl_oe_o, ad_oe, up_oe, pullup_en_o, cycle_done_o;
	reset_bus_pkg::cycle_req_type req_i = '0;
	reset_bus_pkg::bus_ctrl_type ctrl_o;
	logic [15:0] ad;
	logic [3:0] up;
	int failures = 0;
	int checks_done = 0;

	reset_entry_bus_state_control uut (
		.clock_i,
		.resetn_i,
		.reset_request_n_i(rq_n),
		.req_i,
		.low_power_i,
		.top_address_strap_pin_i(top_pin),
		.core_reset_o,
		.test_isolation_strap_o,
		.ctrl_o,
		.ctrl_oe_o,
		.muxed_addr_data_lines_o(ad),
		.muxed_addr_data_lines_oe_o(ad_oe),
		.upper_address_pins_o(up),
		.upper_address_pins_oe_o(up_oe),
		.pullup_en_o,
		.cycle_done_o
	);
	reset_supervisor_model partner (
		.clock_i,
		.hold_reset_i(hold_reset),
		.strap_low_i(strap_low),
		.pin_oe_i(up_oe),
		.pin_drive_i(up[3]),
		.pullup_en_i(pullup_en_o),
		.reset_request_n_o(rq_n),
		.top_pin_o(top_pin)
	);

	task automatic cmp_bit(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (failures == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_core(input logic lvl);
		for (int i = 0; i < 20 && core_reset_o !== lvl; i++) begin
			@(negedge clock_i);
		end
		cmp_bit(core_reset_o, lvl);
	endtask
	task automatic run_row(input row_type r);
		@(negedge clock_i);
		req_i <= '{1'b1, reset_bus_pkg::cycle_kind_type'(r.kind), r.addr,
			4'h0, r.wdata, 1'b0};
		@(negedge clock_i);
		if (r.chk) begin
			cmp_word(16'(ctrl_o), 16'(r.ctrl1));
			cmp_bit(ad_oe, r.oe1);
			if (r.kind == 3'h3) cmp_word(16'(up), 16'h000f);
			else cmp_word(ad, r.addr);
		end
		@(negedge clock_i);
		if (r.chk) begin
			cmp_word(16'(ctrl_o), 16'(r.ctrl2));
			cmp_bit(ad_oe, r.oe2);
			if (r.kind == 3'h2) cmp_word(ad, r.wdata);
		end
		@(negedge clock_i);
		if (r.chk) cmp_bit(cycle_done_o, 1'b1);
		req_i.valid <= 1'b0;
	endtask
	// reset request lands in the middle of a read
	task automatic warm(input logic s);
		@(negedge clock_i);
		hold_reset <= 1'b1;
		strap_low <= s;
		@(negedge clock_i);
		req_i <= '{1'b1, reset_bus_pkg::CYC_READ, 16'h0f0f, 4'h0,
			16'h0000, 1'b0};
		@(negedge clock_i);
		cmp_bit(core_reset_o, 1'b0);
		wait_core(1'b1);
		cmp_word(16'(ctrl_o), 16'h0000);
		cmp_bit(ctrl_oe_o, 1'b1);
		req_i.valid <= 1'b0;
		@(negedge clock_i);
		cmp_bit(ctrl_oe_o, 1'b0);
		cmp_bit(up_oe, 1'b0);
		cmp_bit(pullup_en_o, 1'b1);
		hold_reset <= 1'b0;
		wait_core(1'b0);
		cmp_bit(test_isolation_strap_o, s);
		cmp_bit(up_oe, 1'b1);
		strap_low <= 1'b0;
	endtask

	initial forever #20 clock_i = ~clock_i;
	initial begin
		#(40 * 3000);
		failures++;
		conclude();
	end
	initial begin
		repeat (16) @(negedge clock_i);
		cmp_bit(ctrl_oe_o, 1'b0);
		cmp_bit(pullup_en_o, 1'b1);
		cmp_bit(core_reset_o, 1'b1);
		resetn_i <= 1'b1;
		wait_core(1'b0);
		cmp_bit(test_isolation_strap_o, 1'b0);
		foreach (rows[i]) run_row(rows[i]);
		run_row(rows[1]);
		@(negedge clock_i);
		low_power_i <= 1'b1;
		req_i.valid <= 1'b1;
		repeat (4) begin
			@(negedge clock_i);
			cmp_bit(cycle_done_o, 1'b0);
		end
		cmp_word(ad, 16'h0000);
		cmp_bit(ad_oe, 1'b1);
		cmp_word(16'(up), 16'h0000);
		low_power_i <= 1'b0;
		req_i.valid <= 1'b0;
		warm(1'b1);
		warm(1'b0);
		run_row(rows[0]);
		conclude();
	end
endmodule
